// File: design/atc_pkg.sv
// shared constants and carrier types for the adc test/config register bank
package atc_pkg;
	localparam logic [15:0] OFS_PROBE_LOW = 16'h103A;
	localparam logic [15:0] OFS_CHASSIS = 16'h103C;
	localparam logic [15:0] OFS_SIM_PUSH = 16'h103E;
	localparam logic [15:0] OFS_TALLY_CLR = 16'h1040;
	localparam logic [15:0] OFS_RD_PROBE = 16'h1064;
	localparam logic [15:0] OFS_SOFT_CONV = 16'h1068;
	localparam logic [15:0] OFS_RAMP_FIXED = 16'h106A;
	localparam logic [15:0] OFS_CONV_A = 16'h1070;
	localparam logic [15:0] OFS_CONV_B = 16'h1072;
	localparam logic [15:0] OFS_LIMIT_FIRST = 16'h1080;
	localparam logic [15:0] OFS_LIMIT_LAST = 16'h10BE;
	localparam logic [15:0] OFS_ROM_FIRST = 16'h8000;
	localparam logic [15:0] OFS_MAKER2 = 16'h8026;
	localparam logic [15:0] OFS_MAKER1 = 16'h802A;
	localparam logic [15:0] OFS_MAKER0 = 16'h802E;
	localparam logic [15:0] OFS_VERSION = 16'h8032;
	localparam logic [15:0] OFS_BOARD2 = 16'h8036;
	localparam logic [15:0] OFS_BOARD1 = 16'h803A;
	localparam logic [15:0] OFS_BOARD0 = 16'h803E;
	localparam logic [15:0] OFS_HW_REV = 16'h804E;
	localparam logic [15:0] OFS_SERIAL_HI = 16'h8F02;
	localparam logic [15:0] OFS_SERIAL_LO = 16'h8F06;
	// 32-channel variant: one limit word every two bytes
	localparam int LIMIT_STRIDE_SHIFT = 1;
	localparam int CHANNELS = 32;
	localparam int SIM_DEPTH = 32;
	localparam int BUF_DEPTH = 8;
	localparam int WORD_W = 32;
	localparam int TALLY_W = 24;
	localparam int ADDR_W = 11;
	localparam int KILL_BIT = 8;
	localparam int OV_BIT = 12;
	localparam logic [4:0] SIM_LAST = 5'h1F;
	localparam logic [7:0] RAMP_FIXED_RESET = 8'h00;
	localparam logic [7:0] CHASSIS_RESET = 8'h00;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} atc_req_type;

	typedef struct packed {
		logic ack;
		logic [15:0] rdata;
	} atc_rsp_type;

	typedef struct packed {
		logic ov;
		logic [11:0] value;
	} atc_sample_type;
endpackage

// File: design/atc_bank.sv
// register bank, simulated-event store and output word buffer
`timescale 1ns/1ps

module atc_word_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int PW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] wrPtr;
		logic [PW-1:0] rdPtr;
		logic [PW:0] count;
		logic notFull;
		logic notEmpty;
	} atc_fifo_state_type;

	atc_fifo_state_type s_q, s_d;
	logic push;
	logic pop;

	always_comb
	begin
		s_d = s_q;
		push = inValid && s_q.notFull;
		pop = outReady && s_q.notEmpty;
		if (push)
		begin
			s_d.mem[s_q.wrPtr] = inData;
			s_d.wrPtr = s_q.wrPtr + 1'b1;
		end
		if (pop)
			s_d.rdPtr = s_q.rdPtr + 1'b1;
		if (push && !pop)
			s_d.count = s_q.count + 1'b1;
		else if (pop && !push)
			s_d.count = s_q.count - 1'b1;
		s_d.notFull = (s_d.count != (PW+1)'(DEPTH));
		// valid comes from its own flop so the consumer sees no decode glitch
		s_d.notEmpty = (s_d.count != '0);
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s_q <= '0;
			s_q.notFull <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	assign inReady = s_q.notFull;
	assign outValid = s_q.notEmpty;
	assign outData = s_q.mem[s_q.rdPtr];
endmodule

// Summary of operation
// [R1] write 0x103A loads probe word low half
// [R2] low-half write stores full probe word
// [R3] chassis index register read/write at 0x103C
// [R4] chassis index inserted in output words
// [R5] write 0x103E pushes 32-entry simulated event
// [R6] simulation select replaces conversions with stored event
// [R7] test word: 12-bit value plus overflow
// [R8] host loads words in readout channel order
// [R9] exactly 32 words; extra writes wrap
// [R10] write 0x1040 clears event tally; a gate trigger in that cycle while not streaming increments it instead
// [R11] 0x1064 holds 11-bit buffer read address
// [R12] host keeps read and write addresses distinct
// [R13] write 0x1068 starts one test conversion
// [R14] 0x106A holds 8-bit fixed ramp level
// [R15] ramp enable off selects fixed level
// [R16] 0x1070 returns converter A value
// [R17] 0x1072 returns converter B value
// [R18] one limit word per channel, stride two
// [R19] kill bit suppresses channel storage
// [R20] limit compared with value's top eight bits
// [R21] low limit check drops data not above
// [R22] limits cleared only by hardware reset
// [R23] read-only identification region 0x8000-0xFFFE
// [R24] maker code three bytes, most significant first
// [R25] writes to read-only ignored; write-only reads zero
module atc_bank #(
	parameter logic [7:0] MAKER_CODE2 = 8'hA1, // arbitrary value
	parameter logic [7:0] MAKER_CODE1 = 8'hB2, // arbitrary value
	parameter logic [7:0] MAKER_CODE0 = 8'hC3, // arbitrary value
	parameter logic [7:0] VERSION_CODE = 8'hD4, // arbitrary value
	parameter logic [7:0] BOARD_TYPE2 = 8'h1E, // arbitrary value
	parameter logic [7:0] BOARD_TYPE1 = 8'h2F, // arbitrary value
	parameter logic [7:0] BOARD_TYPE0 = 8'h3A, // arbitrary value
	parameter logic [7:0] HW_REVISION = 8'h4B, // arbitrary value
	parameter logic [7:0] SERIAL_HIGH = 8'h5C, // arbitrary value
	parameter logic [7:0] SERIAL_LOW = 8'h6D // arbitrary value
) (
	input wire logic clk,
	input wire logic rstn,
	input wire atc_pkg::atc_req_type busReq,
	output atc_pkg::atc_rsp_type busRsp,
	input wire logic [15:0] probeHigh,
	input wire logic [10:0] probeWriteAddr,
	output logic bufWrite,
	output logic [10:0] bufWriteAddr,
	output logic [31:0] bufWriteData,
	output logic [10:0] bufReadProbeAddr,
	input wire logic acquisitionSimSelect,
	input wire logic lowLimitEnable,
	input wire logic ramp_enable,
	input wire logic [7:0] rampSlideLevel,
	output logic [7:0] rampDacLevel,
	input wire logic gate,
	output logic convStart,
	output logic [7:0] chassisIndex,
	output logic [23:0] eventTally,
	input wire logic convAStrobe,
	input wire logic [11:0] convAIn,
	input wire logic convBStrobe,
	input wire logic [11:0] convBIn,
	input wire logic sampleValid,
	output logic sampleReady,
	input wire logic [4:0] sampleChannel,
	input wire atc_pkg::atc_sample_type sampleData,
	output logic wordValid,
	input wire logic wordReady,
	output logic [31:0] wordData
);
	typedef struct packed {
		atc_pkg::atc_rsp_type rsp;
		logic [15:0] probeLow;
		logic bufWrite;
		logic [10:0] bufWriteAddr;
		logic [31:0] bufWriteData;
		logic [10:0] readProbe;
		logic [7:0] chassis;
		logic [7:0] rampFixed;
		logic [7:0] rampOut;
		logic [11:0] convA;
		logic [11:0] convB;
		logic [23:0] tally;
		logic convStart;
		logic [atc_pkg::SIM_DEPTH-1:0][12:0] simMem;
		logic [4:0] simWrPtr;
		logic [4:0] simRdPtr;
		logic simSelPrev;
		logic streaming;
		logic [4:0] streamCount;
		logic [atc_pkg::CHANNELS-1:0][8:0] limits;
	} atc_bank_state_type;

	atc_bank_state_type s_q, s_d;
	logic bufInValid;
	logic bufInReady;
	logic [31:0] bufInData;
	logic trigger;
	logic [4:0] limitIdx;
	logic limitHit;

	function automatic logic [31:0] atc_pack(input logic [7:0] crate, input logic [4:0] ch,
		input logic [12:0] ovValue);
		atc_pack = {crate, 3'h0, ch, 3'h0, ovValue}; // R4
	endfunction

	function automatic logic atc_keep(input logic [8:0] lim, input logic [11:0] value,
		input logic checkOn);
		atc_keep = !lim[atc_pkg::KILL_BIT] && (!checkOn || value[11:4] > lim[7:0]); // R19 R20 R21
	endfunction

	always_comb
	begin
		s_d = s_q;
		s_d.rsp = '0;
		s_d.bufWrite = 1'b0;
		s_d.convStart = 1'b0;
		bufInValid = 1'b0;
		bufInData = '0;
		limitIdx = busReq.addr[5:1];
		limitHit = (busReq.addr >= atc_pkg::OFS_LIMIT_FIRST)
			&& (busReq.addr <= atc_pkg::OFS_LIMIT_LAST);
		trigger = gate || (busReq.wr && busReq.addr == atc_pkg::OFS_SOFT_CONV);

		if (busReq.wr)
		begin
			// read-only offsets and unlisted offsets outside the limit range fall through untouched
			unique case (busReq.addr)
				atc_pkg::OFS_PROBE_LOW:
				begin
					s_d.probeLow = busReq.wdata; // R1
					s_d.bufWrite = 1'b1; // R2
					s_d.bufWriteAddr = probeWriteAddr;
					s_d.bufWriteData = {probeHigh, busReq.wdata}; // R2
				end
				atc_pkg::OFS_CHASSIS: s_d.chassis = busReq.wdata[7:0]; // R3
				atc_pkg::OFS_SIM_PUSH:
				begin
					// circular store: a 33rd write overwrites entry 0
					s_d.simMem[s_q.simWrPtr] = busReq.wdata[12:0]; // R5 R7
					s_d.simWrPtr = s_q.simWrPtr + 5'h01; // R9
				end
				atc_pkg::OFS_TALLY_CLR: s_d.tally = '0; // R10
				atc_pkg::OFS_RD_PROBE: s_d.readProbe = busReq.wdata[10:0]; // R11
				atc_pkg::OFS_SOFT_CONV: s_d.convStart = 1'b1; // R13
				atc_pkg::OFS_RAMP_FIXED: s_d.rampFixed = busReq.wdata[7:0]; // R14
				default:
				begin
					if (limitHit)
						s_d.limits[limitIdx] = busReq.wdata[8:0]; // R18
				end
			endcase
		end

		if (busReq.rd)
		begin
			s_d.rsp.ack = 1'b1;
			unique case (busReq.addr)
				atc_pkg::OFS_CHASSIS: s_d.rsp.rdata = {8'h00, s_q.chassis}; // R3
				atc_pkg::OFS_RAMP_FIXED: s_d.rsp.rdata = {8'h00, s_q.rampFixed}; // R14
				atc_pkg::OFS_CONV_A: s_d.rsp.rdata = {4'h0, s_q.convA}; // R16
				atc_pkg::OFS_CONV_B: s_d.rsp.rdata = {4'h0, s_q.convB}; // R17
				atc_pkg::OFS_MAKER2: s_d.rsp.rdata = {8'h00, MAKER_CODE2}; // R24
				atc_pkg::OFS_MAKER1: s_d.rsp.rdata = {8'h00, MAKER_CODE1}; // R24
				atc_pkg::OFS_MAKER0: s_d.rsp.rdata = {8'h00, MAKER_CODE0}; // R24
				atc_pkg::OFS_VERSION: s_d.rsp.rdata = {8'h00, VERSION_CODE}; // R23
				atc_pkg::OFS_BOARD2: s_d.rsp.rdata = {8'h00, BOARD_TYPE2}; // R23
				atc_pkg::OFS_BOARD1: s_d.rsp.rdata = {8'h00, BOARD_TYPE1}; // R23
				atc_pkg::OFS_BOARD0: s_d.rsp.rdata = {8'h00, BOARD_TYPE0}; // R23
				atc_pkg::OFS_HW_REV: s_d.rsp.rdata = {8'h00, HW_REVISION}; // R23
				atc_pkg::OFS_SERIAL_HI: s_d.rsp.rdata = {8'h00, SERIAL_HIGH}; // R23
				atc_pkg::OFS_SERIAL_LO: s_d.rsp.rdata = {8'h00, SERIAL_LOW}; // R23
				default:
				begin
					// write-only offsets and unused ROM bytes read as zero
					if (limitHit)
						s_d.rsp.rdata = {7'h00, s_q.limits[limitIdx]}; // R18
					else
						s_d.rsp.rdata = 16'h0000; // R25
				end
			endcase
		end

		if (convAStrobe)
			s_d.convA = convAIn; // R16
		if (convBStrobe)
			s_d.convB = convBIn; // R17

		s_d.rampOut = ramp_enable ? rampSlideLevel : s_q.rampFixed; // R15

		// entering simulation resets the write side; leaving resets the read side
		s_d.simSelPrev = acquisitionSimSelect;
		if (acquisitionSimSelect && !s_q.simSelPrev)
		begin
			s_d.simWrPtr = '0;
			s_d.streaming = 1'b0;
		end
		if (!acquisitionSimSelect && s_q.simSelPrev)
			s_d.simRdPtr = '0;

		if (trigger && !s_q.streaming)
		begin
			s_d.tally = s_q.tally + 24'h00_0001;
			if (acquisitionSimSelect)
			begin
				s_d.streaming = 1'b1; // R6
				s_d.streamCount = '0;
			end
		end

		if (s_q.streaming)
		begin
			// one stored word per buffer slot; stalls while the buffer is full
			bufInValid = 1'b1; // R6
			bufInData = atc_pack(s_q.chassis, s_q.streamCount, s_q.simMem[s_q.simRdPtr]);
			if (bufInReady)
			begin
				s_d.simRdPtr = s_q.simRdPtr + 5'h01;
				s_d.streamCount = s_q.streamCount + 5'h01;
				if (s_q.streamCount == atc_pkg::SIM_LAST)
					s_d.streaming = 1'b0;
			end
		end
		else if (sampleValid && !acquisitionSimSelect
			&& atc_keep(s_q.limits[sampleChannel], sampleData.value, lowLimitEnable))
		begin
			bufInValid = 1'b1;
			bufInData = atc_pack(s_q.chassis, sampleChannel, sampleData); // R4
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			// limits included: only the hardware reset clears them
			s_q <= '0; // R22
			s_q.chassis <= atc_pkg::CHASSIS_RESET;
			s_q.rampFixed <= atc_pkg::RAMP_FIXED_RESET;
		end
		else
			s_q <= s_d;
	end

	atc_word_fifo #(
		.WIDTH(atc_pkg::WORD_W),
		.DEPTH(atc_pkg::BUF_DEPTH)
	) u_buf (
		.clk(clk),
		.rstn(rstn),
		.inValid(bufInValid),
		.inReady(bufInReady),
		.inData(bufInData),
		.outValid(wordValid),
		.outReady(wordReady),
		.outData(wordData)
	);

	// samples are refused while simulated words stream or the buffer is full
	assign sampleReady = bufInReady && !s_q.streaming;
	assign busRsp = s_q.rsp;
	assign bufWrite = s_q.bufWrite;
	assign bufWriteAddr = s_q.bufWriteAddr;
	assign bufWriteData = s_q.bufWriteData;
	assign bufReadProbeAddr = s_q.readProbe;
	assign rampDacLevel = s_q.rampOut;
	assign convStart = s_q.convStart;
	assign chassisIndex = s_q.chassis;
	assign eventTally = s_q.tally;
endmodule

// File: tb/atc_host.sv
// register bus master model driving the bank's request port
`timescale 1ns/1ps

module atc_host (
	input wire logic clk,
	output atc_pkg::atc_req_type busReq,
	input wire atc_pkg::atc_rsp_type busRsp
);
	initial busReq = '0;

	// released lines show the inverse so a stale value never looks valid
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		busReq = {2'b10, a, d};
		@(negedge clk);
		busReq = {2'b00, ~a, ~d};
	endtask

	// answer is registered: ack stands in the cycle after the taking edge,
	// so it is taken mid-cycle, away from the edge that replaces it
	task automatic rd(input logic [15:0] a, output logic [16:0] r);
		@(negedge clk);
		busReq = {2'b01, a, ~busReq.wdata};
		@(negedge clk);
		r = busRsp;
		busReq = {2'b00, ~a, busReq.wdata};
	endtask
endmodule

// File: tb/atc_bank_chk.sv
// bound assertions on the register bank's ports
`timescale 1ns/1ps

module atc_bank_chk (
	input wire logic clk,
	input wire logic rstn,
	input wire atc_pkg::atc_req_type busReq,
	input wire atc_pkg::atc_rsp_type busRsp,
	input wire logic [15:0] probeHigh,
	input wire logic bufWrite,
	input wire logic [31:0] bufWriteData,
	input wire logic [10:0] bufReadProbeAddr,
	input wire logic ramp_enable,
	input wire logic [7:0] rampSlideLevel,
	input wire logic [7:0] rampDacLevel,
	input wire logic gate,
	input wire logic convStart,
	input wire logic [7:0] chassisIndex,
	input wire logic [23:0] eventTally,
	input wire logic wordValid,
	input wire logic [31:0] wordData
);
	wire [15:0] a = busReq.addr;
	wire [15:0] d = busReq.wdata;
	wire w = busReq.wr;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	property p_probe;
		w && a == 16'h103A |=> bufWrite && bufWriteData == {$past(probeHigh), $past(d)};
	endproperty
	a_probe: assert property (p_probe) else $error("probe word not stored");
	property p_chassis;
		w && a == 16'h103C |=> chassisIndex == $past(d[7:0]);
	endproperty
	a_chassis: assert property (p_chassis) else $error("chassis index not loaded");
	property p_word;
		wordValid |-> wordData[31:24] == chassisIndex && wordData[23:21] == 3'h0
			&& wordData[15:13] == 3'h0;
	endproperty
	a_word: assert property (p_word) else $error("output word layout wrong");
	property p_clr;
		w && a == 16'h1040 && !gate |=> eventTally == 24'h00_0000;
	endproperty
	a_clr: assert property (p_clr) else $error("tally not cleared");
	property p_rdadr;
		w && a == 16'h1064 |=> bufReadProbeAddr == $past(d[10:0]);
	endproperty
	a_rdadr: assert property (p_rdadr) else $error("read probe address wrong");
	property p_conv;
		w && a == 16'h1068 |=> convStart ##1 !convStart;
	endproperty
	a_conv: assert property (p_conv) else $error("conversion strobe not one pulse");
	property p_ramp;
		ramp_enable [*2] |-> rampDacLevel == $past(rampSlideLevel);
	endproperty
	a_ramp: assert property (p_ramp) else $error("dac not following sliding level");
	property p_wo;
		busReq.rd && a == 16'h103A |=> busRsp.ack && busRsp.rdata == 16'h0000;
	endproperty
	a_wo: assert property (p_wo) else $error("write-only read not zero");
endmodule

bind atc_bank atc_bank_chk chk (.clk, .rstn, .busReq, .busRsp, .probeHigh, .bufWrite,
	.bufWriteData, .bufReadProbeAddr, .ramp_enable, .rampSlideLevel, .rampDacLevel, .gate,
	.convStart, .chassisIndex, .eventTally, .wordValid, .wordData);

// File: tb/tb.sv
// self-checking bench for the adc test/config register bank
`timescale 1ns/1ps

module tb;
	logic clk, rstn, bufWrite, acquisitionSimSelect, lowLimitEnable, ramp_enable, gate;
	logic convStart, convAStrobe, convBStrobe, sampleValid, sampleReady, wordValid;
	logic wordReady = 1'b0;
	logic [15:0] probeHigh, d;
	logic [10:0] probeWriteAddr, bufWriteAddr, bufReadProbeAddr;
	logic [7:0] rampSlideLevel, rampDacLevel, chassisIndex, chassis;
	logic [23:0] eventTally;
	logic [11:0] convAIn, convBIn;
	logic [4:0] sampleChannel;
	logic [31:0] bufWriteData, wordData, got[$], exq[$];
	logic [8:0] lim[32];
	logic [12:0] sv[33];
	logic [16:0] r;
	atc_pkg::atc_req_type busReq;
	atc_pkg::atc_rsp_type busRsp;
	atc_pkg::atc_sample_type sampleData;
	logic [15:0] romA[13] = '{16'h8026, 16'h802A, 16'h802E, 16'h8032, 16'h8036, 16'h803A,
		16'h803E, 16'h804E, 16'h8F02, 16'h8F06, 16'h8000, 16'h1078, 16'h1040};
	logic [7:0] romV[13] = '{8'hA1, 8'hB2, 8'hC3, 8'hD4, 8'h1E, 8'h2F, 8'h3A, 8'h4B,
		8'h5C, 8'h6D, 8'h00, 8'h00, 8'h00};
	integer seed = 54684;
	int miscompares = 0, check_count = 0, i, j, k;

	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	atc_host host (.clk, .busReq, .busRsp);
	atc_bank uut (.clk, .rstn, .busReq, .busRsp, .probeHigh, .probeWriteAddr, .bufWrite,
		.bufWriteAddr, .bufWriteData, .bufReadProbeAddr, .acquisitionSimSelect,
		.lowLimitEnable, .ramp_enable, .rampSlideLevel, .rampDacLevel, .gate, .convStart,
		.chassisIndex, .eventTally, .convAStrobe, .convAIn, .convBStrobe, .convBIn,
		.sampleValid, .sampleReady, .sampleChannel, .sampleData, .wordValid, .wordReady,
		.wordData);

	// consumer stalls a quarter of the cycles so the fifo fills and refuses
	always @(negedge clk) wordReady <= ($random(seed) & 3) != 0;
	always @(posedge clk) if (wordValid === 1'b1 && wordReady === 1'b1) got.push_back(wordData);

	function automatic logic [31:0] word(input logic [4:0] ch, input logic [12:0] v);
		return {chassis, 3'h0, ch, 3'h0, v};
	endfunction

	function automatic logic keep(input logic [8:0] l, input logic [11:0] v, input logic en);
		return !l[8] && (!en || v[11:4] > l[7:0]);
	endfunction

	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	task rdchk(input string n, input logic [15:0] a, input logic [15:0] e);
		host.rd(a, r);
		chk(n, {1'b1, e}, r);
	endtask

	task flush(input string n);
		for (j = 0; j < 400 && got.size() < exq.size(); j++) @(posedge clk);
		repeat (20) @(posedge clk);
		chk({n, " count"}, exq.size(), got.size());
		while (got.size() > 0 && exq.size() > 0) chk(n, exq.pop_front(), got.pop_front());
		got.delete();
		exq.delete();
		$display("test %s done", n);
	endtask

	task final_report;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk);
		miscompares++;
		final_report;
	end

	initial
	begin
		rstn = 1'b0;
		{acquisitionSimSelect, lowLimitEnable, gate, convAStrobe, convBStrobe, sampleValid} = '0;
		ramp_enable = 1'b1;
		{probeHigh, probeWriteAddr, rampSlideLevel, convAIn, convBIn, sampleChannel} = '0;
		sampleData = '0;
		chassis = 8'h00;
		repeat (3) @(posedge clk);
		@(negedge clk);
		rstn = 1'b1;
		for (i = 0; i < 13; i++)
			rdchk("id", romA[i], {8'h00, romV[i]});
		host.wr(16'h8026, 16'hFFFF);
		rdchk("id ro", 16'h8026, 16'h00A1);
		$display("test id done");
		chassis = $random(seed);
		d = $random(seed);
		host.wr(16'h103C, {8'hFF, chassis});
		rdchk("chassis", 16'h103C, {8'h00, chassis});
		host.wr(16'h106A, d);
		rdchk("ramp const", 16'h106A, {8'h00, d[7:0]});
		@(negedge clk);
		ramp_enable = 1'b0;
		rampSlideLevel = d[15:8];
		repeat (2) @(negedge clk);
		chk("dac fixed", d[7:0], rampDacLevel);
		ramp_enable = 1'b1;
		repeat (2) @(negedge clk);
		chk("dac slide", d[15:8], rampDacLevel);
		probeHigh = $random(seed);
		d = $random(seed);
		probeWriteAddr = d[10:0];
		host.wr(16'h1064, {5'h1F, d[10:0] ^ 11'h001});
		chk("rd addr", d[10:0] ^ 11'h001, bufReadProbeAddr);
		host.wr(16'h103A, d);
		chk("probe", {probeHigh, d}, bufWriteData);
		chk("probe wr", {1'b1, d[10:0]}, {bufWrite, bufWriteAddr});
		rdchk("wo read", 16'h103A, 16'h0000);
		@(negedge clk);
		{convAStrobe, convBStrobe} = 2'b11;
		convAIn = $random(seed);
		convBIn = $random(seed);
		@(negedge clk);
		{convAStrobe, convBStrobe} = 2'b00;
		d = {4'h0, convAIn};
		convAIn = ~convAIn;
		host.wr(16'h1070, 16'hFFFF);
		rdchk("conv a", 16'h1070, d);
		rdchk("conv b", 16'h1072, {4'h0, convBIn});
		$display("test registers done");
		for (i = 0; i < 32; i++)
		begin
			lim[i] = $random(seed);
			lim[i][8] = (i % 4) == 3;
			host.wr(16'(16'h1080 + 2 * i), {7'h7F, lim[i]});
		end
		for (i = 0; i < 32; i++)
			rdchk("limit", 16'(16'h1080 + 2 * i), {7'h00, lim[i]});
		// back-to-back samples; every fourth sits exactly on its limit
		for (i = 0; i < 48; i++)
		begin
			@(negedge clk);
			sampleChannel = $random(seed);
			d = $random(seed);
			if (i % 4 == 0) d[11:4] = lim[sampleChannel][7:0];
			sampleData = d[12:0];
			lowLimitEnable = i[2];
			sampleValid = 1'b1;
			// ready only moves on rising edges, so judging it mid-cycle is race-free
			for (j = 0; j < 50 && sampleReady !== 1'b1; j++) @(negedge clk);
			@(posedge clk);
			if (keep(lim[sampleChannel], d[11:0], lowLimitEnable))
				exq.push_back(word(sampleChannel, d[12:0]));
		end
		@(negedge clk);
		sampleValid = 1'b0;
		flush("samples");
		acquisitionSimSelect = 1'b1;
		repeat (2) @(negedge clk);
		acquisitionSimSelect = 1'b0;
		for (i = 0; i < 33; i++)
		begin
			sv[i] = $random(seed);
			host.wr(16'h103E, {3'h7, sv[i]});
		end
		sv[0] = sv[32];
		acquisitionSimSelect = 1'b1;
		for (k = 0; k < 2; k++)
		begin
			@(negedge clk);
			gate = (k == 0);
			@(negedge clk);
			gate = 1'b0;
			if (k == 1) host.wr(16'h1068, 16'h0000);
			for (i = 0; i < 32; i++) exq.push_back(word(i[4:0], sv[i]));
			flush("sim");
			chk("tally", k + 1, eventTally);
		end
		host.wr(16'h1040, 16'hFFFF);
		chk("tally clr", 0, eventTally);
		rdchk("limit kept", 16'h10BE, {7'h00, lim[31]});
		// a hardware reset in mid-run must wipe the limit words
		@(negedge clk);
		rstn = 1'b0;
		@(negedge clk);
		rstn = 1'b1;
		rdchk("limit rst", 16'h10BE, 16'h0000);
		final_report;
	end
endmodule
